// ===== design/srtc_cfg.svh
// Purpose: constants for the sensor row timing control block
// Assumes: AXI4-Lite, 32-bit data, byte address = 4 * register index
// Notes: definitions only
`ifndef SRTC_CFG_SVH
`define SRTC_CFG_SVH
// register indexes
`define SRTC_IDX_ROW 6'h0A
`define SRTC_IDX_EXTRA 6'h0B
`define SRTC_IDX_SHUT 6'h0C
`define SRTC_IDX_RESTART 6'h0D
`define SRTC_IDX_LAYOUT 6'h10
`define SRTC_IDX_STATUS 6'h11
// reset values
`define SRTC_RST_ROW 16'h0011
`define SRTC_RST_EXTRA 16'h0000
`define SRTC_RST_SHUT 16'h0000
`define SRTC_RST_RESTART 16'h0000
`define SRTC_RST_LAYOUT 32'h0000_0040
// row speed fields
`define SRTC_SPD_LSB 0
`define SRTC_EDGE_LSB 4
`define SRTC_INV_BIT 8
// layout fields
`define SRTC_ONE_ADC_BIT 24
`define SRTC_SHORT_INT_BIT 25
// base vertical blanking in pixel clocks, before extra delay
`define SRTC_VBLANK_BASE 16'h0004
// axi responses
`define SRTC_RESP_OKAY 2'h0
`define SRTC_RESP_SLVERR 2'h2
`endif

// ===== design/srtc_pkg.sv
// Purpose: types of the sensor row timing control block
// Assumes: constants live in srtc_cfg.svh
// Notes: state structs for the idiom of one comb and one ff process
`default_nettype none
package srtc_pkg;
  typedef enum logic [0:0] {SRTC_BLANK, SRTC_ACTIVE} srtc_fsm_t;

  typedef struct packed {
    logic [4:0] cnt;
    logic tick;
    logic level;
  } srtc_div_st_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_held;
    logic [5:0] aw_idx;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [15:0] row;
    logic [15:0] extra;
    logic [15:0] shut;
    logic [15:0] restart;
    logic [31:0] layout;
    logic [15:0] row_s;
    logic [15:0] extra_s;
    logic [15:0] shut_s;
    srtc_fsm_t fsm;
    logic [15:0] cnt;
    logic [15:0] sh_cnt;
    logic sh_run;
    logic fv;
    logic lv;
    logic pix_reset;
    logic bad_frame;
    logic no_image;
    logic [15:0] dly;
    logic strobe;
  } srtc_st_t;
endpackage
`default_nettype wire

// ===== design/srtc_div.sv
// Purpose: divides the master clock into the pixel clock
// Assumes: period is 1..14 master clocks, compared live on every cycle
// Notes: a period of 1 leaves the level high and ticks every cycle
`default_nettype none
module srtc_div (
  input wire logic aclk, // master clock
  input wire logic aresetn, // sync reset, active low
  input wire logic [4:0] period, // pixel clock period in master clocks
  output logic tick, // one-cycle pulse at each pixel period start
  output logic level // pixel clock level, high in first half
);
  import srtc_pkg::*;

  srtc_div_st_t q;
  srtc_div_st_t next_q;
  logic [4:0] half;

  // ************************************************************
  // counter and level
  // ************************************************************
  always_comb begin
    next_q = q;
    half = (period + 5'h01) >> 1;
    next_q.tick = 1'b0;
    if (q.cnt >= period - 5'h01) begin // see [RULE1]
      next_q.cnt = 5'h00;
      next_q.tick = 1'b1;
    end else begin
      next_q.cnt = q.cnt + 5'h01;
    end
    next_q.level = (next_q.cnt < half);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign tick = q.tick;
  assign level = q.level;

  // ticks at period 2 are spaced by exactly two master clocks; a period that changes
  // right after a tick sets the next gap itself, so it stays out of the antecedent
  chk_div_spacing: assert property (@(posedge aclk) disable iff (!aresetn) // see [RULE1]
    ((q.tick && period == 5'h02 && $stable(period)) ##1 period == 5'h02) |-> !q.tick ##1 q.tick)
    else $error("pixel tick spacing wrong");
endmodule
`default_nettype wire

// ===== design/srtc_top.sv
// Purpose: sensor core readout timing with registers over AXI4-Lite
// Assumes: one clock aclk at 250 MHz, sync active-low reset
// Notes: a frame is one active row followed by vertical blanking
// Functional notes
// [RULE1] pixel period is N masters with two converters, 2N with one
// [RULE2] speed zero acts as one and reads back as one
// [RULE3] vertical blanking grows by extra-delay pixel clock periods
// [RULE4] extra-delay change corrupts a frame only under short integration
// [RULE5] shutter delay spaces row sampling end from pixel reset start
// [RULE6] shutter delay beyond row time yields no valid image
// [RULE7] field 7:4 delays the pixel clock edge against frame and line valid
// [RULE8] host keeps reserved bit 3 of row speed at default
// [RULE9] inversion bit selects rising or falling delayed edge
// [RULE10] speed, extra and shutter settings take effect at frame start
//
// Implementation choice: the AXI4-Lite interface to the registers.
`default_nettype none
`include "srtc_cfg.svh"
module srtc_top (
  input wire logic aclk, // master clock
  input wire logic aresetn, // sync reset, active low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic pixel_strobe_out, // delayed pixel clock
  output logic frame_valid_out, // frame valid
  output logic line_valid_out, // line valid
  output logic pixel_reset_out // one-cycle pulse starting a row reset
);
  import srtc_pkg::*;

  srtc_st_t q;
  srtc_st_t next_q;
  logic tick;
  logic level;
  logic [4:0] period;
  logic [15:0] row_len;
  logic [15:0] blank_len;
  logic [15:0] wmask;
  logic do_write;
  logic [31:0] rd_val;
  logic rd_ok;

  // ************************************************************
  // pixel clock divider
  // ************************************************************
  // shadowed speed but live converter bit, so a layout write can change the period mid-frame
  assign period = q.layout[`SRTC_ONE_ADC_BIT] ? {1'b0, q.row_s[2:0], 1'b0}
                                             : {2'b00, q.row_s[2:0]}; // see [RULE1] [RULE10]

  srtc_div u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .period(period),
    .tick(tick),
    .level(level)
  );

  // ************************************************************
  // timing helpers
  // ************************************************************
  assign row_len = (q.layout[15:0] == 16'h0000) ? 16'h0001 : q.layout[15:0];
  assign blank_len = `SRTC_VBLANK_BASE + q.extra_s; // see [RULE3]
  assign wmask = {{8{q.wstrb[1]}}, {8{q.wstrb[0]}}};
  assign do_write = q.aw_held && q.w_held && !q.bvalid;

  // read mux; unmapped addresses answer slave error
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    case (s_axi_araddr[7:2])
      `SRTC_IDX_ROW: rd_val = {16'h0000, q.row};
      `SRTC_IDX_EXTRA: rd_val = {16'h0000, q.extra};
      `SRTC_IDX_SHUT: rd_val = {16'h0000, q.shut};
      `SRTC_IDX_RESTART: rd_val = {16'h0000, q.restart};
      `SRTC_IDX_LAYOUT: rd_val = q.layout;
      `SRTC_IDX_STATUS: rd_val = {29'h0000_0000, q.fv, q.no_image, q.bad_frame};
      default: rd_ok = 1'b0;
    endcase
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    next_q = q;
    next_q.pix_reset = 1'b0;
    // write channel: address and data taken in either order
    if (s_axi_awvalid && q.awready) begin
      next_q.aw_held = 1'b1;
      next_q.aw_idx = s_axi_awaddr[7:2];
    end
    if (s_axi_wvalid && q.wready) begin
      next_q.w_held = 1'b1;
      next_q.wdata = s_axi_wdata;
      next_q.wstrb = s_axi_wstrb;
    end
    if (do_write) begin
      next_q.aw_held = 1'b0;
      next_q.w_held = 1'b0;
      next_q.bvalid = 1'b1;
      next_q.bresp = `SRTC_RESP_OKAY;
      case (q.aw_idx)
        `SRTC_IDX_ROW: begin
          // reserved bits are stored as written; host keeps them, see [RULE8]
          next_q.row = (q.row & ~wmask) | (q.wdata[15:0] & wmask);
          if (next_q.row[2:0] == 3'h0) begin
            next_q.row[2:0] = 3'h1; // see [RULE2]
          end
        end
        `SRTC_IDX_EXTRA: next_q.extra = (q.extra & ~wmask) | (q.wdata[15:0] & wmask);
        `SRTC_IDX_SHUT: next_q.shut = (q.shut & ~wmask) | (q.wdata[15:0] & wmask);
        `SRTC_IDX_RESTART: next_q.restart = (q.restart & ~wmask) | (q.wdata[15:0] & wmask);
        `SRTC_IDX_LAYOUT: begin
          for (int b = 0; b < 4; b++) begin
            if (q.wstrb[b]) begin
              next_q.layout[8*b +: 8] = q.wdata[8*b +: 8];
            end
          end
        end
        `SRTC_IDX_STATUS: begin
          if (q.wstrb[0] && q.wdata[0]) begin
            next_q.bad_frame = 1'b0;
          end
        end
        default: next_q.bresp = `SRTC_RESP_SLVERR;
      endcase
    end
    if (q.bvalid && s_axi_bready) begin
      next_q.bvalid = 1'b0;
    end
    next_q.awready = !next_q.aw_held;
    next_q.wready = !next_q.w_held;
    // read channel: one read outstanding, address taken only while idle
    if (s_axi_arvalid && q.arready) begin
      next_q.rvalid = 1'b1;
      next_q.rdata = rd_val;
      next_q.rresp = rd_ok ? `SRTC_RESP_OKAY : `SRTC_RESP_SLVERR;
    end else if (q.rvalid && s_axi_rready) begin
      next_q.rvalid = 1'b0;
    end
    next_q.arready = !next_q.rvalid;
    // frame sequencer, advanced once per pixel clock
    if (tick) begin
      next_q.cnt = q.cnt + 16'h0001;
      case (q.fsm)
        SRTC_ACTIVE: begin
          if (q.cnt >= row_len - 16'h0001) begin
            next_q.fsm = SRTC_BLANK;
            next_q.cnt = 16'h0000;
            next_q.fv = 1'b0;
            next_q.lv = 1'b0;
            // row sampling ends here; start the shutter wait, see [RULE5]
            next_q.sh_cnt = {2'b00, q.shut_s[13:0]};
            next_q.sh_run = 1'b1;
          end
        end
        SRTC_BLANK: begin
          if (q.cnt >= blank_len - 16'h0001) begin // see [RULE3]
            next_q.fsm = SRTC_ACTIVE;
            next_q.cnt = 16'h0000;
            // frame start: take up pending settings, see [RULE10]
            next_q.row_s = q.row;
            next_q.extra_s = q.extra;
            next_q.shut_s = q.shut;
            // only short integration makes an extra-delay change spoil a frame
            if (q.extra != q.extra_s && q.layout[`SRTC_SHORT_INT_BIT]) begin
              next_q.bad_frame = 1'b1; // see [RULE4]
            end
            // judge the shutter being taken up, not the one it replaces, see [RULE6]
            next_q.fv = (q.shut[13:0] <= row_len[13:0]);
            next_q.lv = (q.shut[13:0] <= row_len[13:0]);
          end
        end
        default: begin
          next_q.fsm = SRTC_BLANK;
          next_q.cnt = 16'h0000;
        end
      endcase
      if (q.sh_run) begin
        if (q.sh_cnt == 16'h0000) begin
          next_q.sh_run = 1'b0;
          next_q.pix_reset = 1'b1; // see [RULE5]
        end else begin
          next_q.sh_cnt = q.sh_cnt - 16'h0001;
        end
      end
    end
    // shutter delay too long for the row: no image; follows the shadow in force
    // so that it agrees with frame valid unless a layout write changes the row length mid-frame, see [RULE6]
    next_q.no_image = (next_q.shut_s[13:0] > row_len[13:0]);
    // edge delay line in master clocks, then optional inversion
    next_q.dly = {q.dly[14:0], level};
    next_q.strobe = q.dly[q.row_s[7:4]] ^ q.row_s[`SRTC_INV_BIT]; // see [RULE7] [RULE9]
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.row <= `SRTC_RST_ROW;
      q.extra <= `SRTC_RST_EXTRA;
      q.shut <= `SRTC_RST_SHUT;
      q.restart <= `SRTC_RST_RESTART;
      q.layout <= `SRTC_RST_LAYOUT;
      q.row_s <= `SRTC_RST_ROW;
      q.extra_s <= `SRTC_RST_EXTRA;
      q.shut_s <= `SRTC_RST_SHUT;
      q.fsm <= SRTC_BLANK;
    end else begin
      q <= next_q;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign pixel_strobe_out = q.strobe;
  assign frame_valid_out = q.fv;
  assign line_valid_out = q.lv;
  assign pixel_reset_out = q.pix_reset;

  // ************************************************************
  // checks
  // ************************************************************
  chk_speed_nonzero: assert property (@(posedge aclk) disable iff (!aresetn) // see [RULE2]
    q.row[2:0] != 3'h0 && q.row_s[2:0] != 3'h0)
    else $error("pixel speed field holds zero");
  chk_period_mode: assert property (@(posedge aclk) disable iff (!aresetn) // see [RULE1]
    period == (q.layout[`SRTC_ONE_ADC_BIT] ? 5'(2 * q.row_s[2:0]) : 5'(q.row_s[2:0])))
    else $error("pixel period does not match mode");
  chk_shadow_hold: assert property (@(posedge aclk) disable iff (!aresetn) // see [RULE10]
    (q.fsm == SRTC_ACTIVE && $past(q.fsm) == SRTC_ACTIVE) |-> $stable(q.row_s) && $stable(q.shut_s))
    else $error("settings changed mid-frame");
  chk_blank_len: assert property (@(posedge aclk) disable iff (!aresetn) // see [RULE3]
    q.fsm == SRTC_BLANK |-> q.cnt < blank_len)
    else $error("blanking ran past base plus extra");
  chk_bad_cause: assert property (@(posedge aclk) disable iff (!aresetn) // see [RULE4]
    $rose(q.bad_frame) |-> $past(q.layout[`SRTC_SHORT_INT_BIT]))
    else $error("bad frame without short integration");
  chk_reset_after: assert property (@(posedge aclk) disable iff (!aresetn) // see [RULE5]
    q.pix_reset |-> $past(q.sh_run) && $past(q.sh_cnt) == 16'h0000 && $past(tick))
    else $error("pixel reset not at end of shutter wait");
  chk_no_image: assert property (@(posedge aclk) disable iff (!aresetn) // see [RULE6]
    (q.no_image && q.fsm == SRTC_ACTIVE && $past(q.fsm) == SRTC_BLANK) |-> !q.fv)
    else $error("frame valid raised with no image");
  chk_strobe_tap: assert property (@(posedge aclk) disable iff (!aresetn) // see [RULE7] [RULE9]
    q.strobe == ($past(q.dly[q.row_s[7:4]]) ^ $past(q.row_s[`SRTC_INV_BIT])))
    else $error("strobe not from selected delay tap");
endmodule
`default_nettype wire

// ===== sim/srtc_host.sv
// Purpose: host model that drives the register bus of srtc_top
// Assumes: AXI4-Lite, at most one write and one read under way
// Notes: address and data lines that have been released show the inverse of the last value
`default_nettype none
`include "srtc_cfg.svh"
module srtc_host (
  input wire logic aclk, // master clock
  output logic [7:0] awaddr, // write address
  output logic awvalid, // write address valid
  input wire logic awready, // write address ready
  output logic [31:0] wdata, // write data
  output logic [3:0] wstrb, // byte enables
  output logic wvalid, // write data valid
  input wire logic wready, // write data ready
  input wire logic [1:0] bresp, // write response
  input wire logic bvalid, // write response valid
  output logic bready, // write response ready
  output logic [7:0] araddr, // read address
  output logic arvalid, // read address valid
  input wire logic arready, // read address ready
  input wire logic [31:0] rdata, // read data
  input wire logic [1:0] rresp, // read response
  input wire logic rvalid, // read data valid
  output logic rready // read data ready
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // bus master
  // ****************************************
  // idle bus from time zero
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
  end
  // both channels offered at once, each dropped at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    // reserved speed bit is always sent at its reset level
    if (a == {`SRTC_IDX_ROW, 2'h0}) d[3] = |(`SRTC_RST_ROW & 16'h0008);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (aw && awready) begin
        aw = 1'b0;
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (w && wready) begin
        w = 1'b0;
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    end while (aw || w);
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  // read: rready is held up until the data is seen
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    araddr <= ~a;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== sim/tb.sv
// Purpose: self-checking bench for srtc_top
// Assumes: srtc_host drives the register bus, one row per frame
// Notes: timings compare cycle stamps, so fixed pipeline offsets cancel
`default_nettype none
`include "srtc_cfg.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] A_ROW = {`SRTC_IDX_ROW, 2'h0};
  localparam logic [7:0] A_EXT = {`SRTC_IDX_EXTRA, 2'h0};
  localparam logic [7:0] A_SHT = {`SRTC_IDX_SHUT, 2'h0};
  localparam logic [7:0] A_RST = {`SRTC_IDX_RESTART, 2'h0};
  localparam logic [7:0] A_LAY = {`SRTC_IDX_LAYOUT, 2'h0};
  localparam logic [7:0] A_STA = {`SRTC_IDX_STATUS, 2'h0};
  localparam logic [7:0] ADR [5] = '{A_ROW, A_EXT, A_SHT, A_RST, A_LAY};
  localparam logic [31:0] RST [5] = '{`SRTC_RST_ROW, `SRTC_RST_EXTRA, `SRTC_RST_SHUT,
    `SRTC_RST_RESTART, `SRTC_RST_LAYOUT};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic strobe, fv, lv, prst;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int t0, t1, t2, g;
  // ****************************************
  // harness
  // ****************************************
  // 250 MHz clock and a cycle stamp for timing checks
  always #2 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;
  srtc_host host (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  srtc_top i_srtc_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pixel_strobe_out(strobe), .frame_valid_out(fv), .line_valid_out(lv),
    .pixel_reset_out(prst));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // watched events: 0 fv rise, 1 strobe rise, 2 strobe fall, 3 reset pulse, 4 fv fall
  function automatic logic sig(input int s);
    case (s)
      0: return fv;
      1: return strobe;
      2: return ~strobe;
      3: return prst;
      default: return ~fv;
    endcase
  endfunction
  // bounded wait for event a, then event b; a lost event counts as a mismatch
  task automatic span(input int a, input int b, output int gap);
    logic p;
    int k;
    for (int n = 0; n < 2; n++) begin
      p = sig(n == 0 ? a : b);
      for (k = 0; k < 3000; k++) begin
        @(posedge aclk);
        #1;
        if (sig(n == 0 ? a : b) === 1'b1 && p !== 1'b1) break;
        p = sig(n == 0 ? a : b);
      end
      // a wait that ran out counts as a mismatch
      chk(k < 3000, 1'b1);
      if (n == 0) t1 = cyc;
    end
    gap = cyc - t1;
  endtask
  // settings move over at frame start, so let two frames pass
  task automatic settle();
    span(0, 0, g);
  endtask
  task automatic wrc(input logic [7:0] a, input logic [31:0] v);
    host.wr(a, v, r);
    chk(r, `SRTC_RESP_OKAY);
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // watchdog at five times the expected run of about two thousand cycles
  initial begin
    #40000;
    err_count++;
    stop_test();
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    foreach (ADR[i]) begin
      host.rd(ADR[i], d, r);
      chk(d, RST[i]);
    end
    wrc(A_ROW, 32'h0000_0018);
    host.rd(A_ROW, d, r);
    chk(d, 32'h0000_0011);
    host.wr(8'h3C, 32'h0000_1234, r);
    chk(r, `SRTC_RESP_SLVERR);
    host.rd(8'h3C, d, r);
    chk(r, `SRTC_RESP_SLVERR);
    chk(d, 32'h0);
    $display("test registers done");
    // row of eight pixel clocks, speed 3 with two then one converter
    wrc(A_LAY, 32'h0000_0008);
    wrc(A_ROW, 32'h0000_0013);
    settle();
    chk({fv, lv}, 2'b11);
    span(1, 1, g);
    chk(g, 3);
    wrc(A_LAY, 32'h0100_0008);
    settle();
    span(1, 1, g);
    chk(g, 6);
    $display("test pixel period done");
    // speed 2: frame is (8 + 4 + extra) * 2 cycles, extra written mid-frame
    wrc(A_LAY, 32'h0000_0008);
    wrc(A_ROW, 32'h0000_0012);
    settle();
    span(0, 4, g);
    chk(g, 16);
    span(0, 0, g);
    // stamp the frame start just seen, then write while its row is still active
    t0 = cyc;
    wrc(A_EXT, 32'h0000_0005);
    chk(cyc - t0 < 16, 1);
    span(0, 0, g);
    chk(t1 - t0, 24);
    chk(g, 34);
    $display("test blanking done");
    // reset pulse moves by shutter * period; beyond the row there is no image
    span(4, 3, t0);
    wrc(A_SHT, 32'h0000_0003);
    settle();
    span(4, 3, g);
    chk(g - t0, 6);
    wrc(A_SHT, 32'h0000_0009);
    repeat (100) @(posedge aclk);
    host.rd(A_STA, d, r);
    chk(d[1], 1'b1);
    t0 = 0;
    repeat (100) begin
      @(posedge aclk);
      if (fv !== 1'b0) t0++;
    end
    chk(t0, 0);
    wrc(A_SHT, 32'h0000_0000);
    settle();
    $display("test shutter done");
    // extra change flags a bad frame only under short integration
    wrc(A_LAY, 32'h0200_0008);
    wrc(A_EXT, 32'h0000_0002);
    settle();
    host.rd(A_STA, d, r);
    chk(d[0], 1'b1);
    wrc(A_STA, 32'h0000_0001);
    host.rd(A_STA, d, r);
    chk(d[0], 1'b0);
    wrc(A_LAY, 32'h0000_0008);
    wrc(A_EXT, 32'h0000_0000);
    settle();
    host.rd(A_STA, d, r);
    chk(d[0], 1'b0);
    $display("test bad frame done");
    // speed 7 leaves room for edge delays of 0 and 3 within one period
    wrc(A_ROW, 32'h0000_0007);
    settle();
    span(0, 1, t0);
    wrc(A_ROW, 32'h0000_0037);
    settle();
    span(0, 1, g);
    chk(g - t0, 3);
    wrc(A_ROW, 32'h0000_0137);
    settle();
    span(0, 2, g);
    chk(g - t0, 3);
    $display("test strobe edge done");
    stop_test();
  end
endmodule
`default_nettype wire
